// ==== rtl/card_socket_ctrl.sv ====
// Notes on behaviour
// R1: decode both sense lines into supply voltage
// R2: hold access open while wait is low
// R3: pulse write strobe low for memory writes
// R4: write strobe marks terminal count, dma read
// R5: card reports write-protect switch on protect line
// R6: protect line is 16-bit port hit in io mode
// R7: protect line serves as dma request
// R8: protect line signals sampled on card clock rising edge
// R9: card clock at half host rate, slow or stop low
// R10: card requests faster clock over clock-run
// R11: warn on clock-run before slowing clock
// R12: reset floats card lines, controller drives levels
// R13: reset asserts anytime, releases on card clock
// R14: attribute select high common, low attribute/io
// R15: output enable marks terminal count, dma write
// R16: each socket fully independent
module card_socket_ctrl
	import card_socket_pkg::*;
(
	input  wire logic                          clock,
	input  wire logic                          rstn,
	// per-socket host side requests
	input  wire logic [SOCKET_COUNT-1:0]       mem_write_req,
	input  wire logic [SOCKET_COUNT-1:0]       attr_space,
	input  wire logic [SOCKET_COUNT-1:0]       io_mode,
	input  wire logic [SOCKET_COUNT-1:0]       dma_read_tc_req,
	input  wire logic [SOCKET_COUNT-1:0]       dma_write_tc_req,
	input  wire logic [SOCKET_COUNT-1:0]       slow_clock_req,
	input  wire logic [SOCKET_COUNT-1:0]       stop_clock_req,
	input  wire logic [SOCKET_COUNT-1:0]       card_reset_req,
	// card pins, sampled through two flops
	input  wire logic [SOCKET_COUNT-1:0]       voltage_sense_one,
	input  wire logic [SOCKET_COUNT-1:0]       voltage_sense_two,
	input  wire logic [SOCKET_COUNT-1:0]       wait_n,
	input  wire logic [SOCKET_COUNT-1:0]       write_protect,
	input  wire logic [SOCKET_COUNT-1:0]       card_clock_run_in,
	// card pin drivers
	output logic      [SOCKET_COUNT-1:0]       write_en_n,
	output logic      [SOCKET_COUNT-1:0]       output_en_n,
	output logic      [SOCKET_COUNT-1:0]       attr_sel_n,
	output logic      [SOCKET_COUNT-1:0]       card_bus_clock,
	output logic      [SOCKET_COUNT-1:0]       card_clock_run_out,
	output logic      [SOCKET_COUNT-1:0]       card_clock_run_oe,
	output logic      [SOCKET_COUNT-1:0]       card_bus_reset_n,
	output logic      [SOCKET_COUNT-1:0]       card_lines_float,
	// status back to host side
	output logic      [SOCKET_COUNT*2-1:0]     card_volt,
	output logic      [SOCKET_COUNT-1:0]       write_done,
	output logic      [SOCKET_COUNT-1:0]       write_protected,
	output logic      [SOCKET_COUNT-1:0]       port_sixteen_bit_ind,
	output logic      [SOCKET_COUNT-1:0]       dma_request
);
	import card_socket_pkg::*;

	// ------------------------------------------------------------
	// decode helper
	// ------------------------------------------------------------
	// sense lines are grounded by the card to signal a lower supply
	function automatic card_volt_e volt_decode(input logic s1, input logic s2);
		case ({s2, s1})
			2'h3:    volt_decode = volt_5v;
			2'h2:    volt_decode = volt_3v;
			2'h1:    volt_decode = volt_xv;
			default: volt_decode = volt_lv;
		endcase
	endfunction : volt_decode

	// write strobe sequence states
	typedef enum logic [1:0] {st_idle, st_strobe, st_wait, st_done} wr_state_e;

	// ------------------------------------------------------------
	// one slice per socket
	// ------------------------------------------------------------
	genvar s;
	generate
		for (s = 0; s < SOCKET_COUNT; s++) begin : g_sock  // [R16]
			// pin synchronisers: first stage read only by the second
			logic [4:0] sync1_reg, sync2_reg;
			// registered state and next values
			wr_state_e  wr_reg, wr_next;
			logic [5:0] str_cnt_reg, str_cnt_next;
			logic [3:0] div_reg, div_next;          // current divider
			logic [3:0] tick_reg, tick_next;        // divider counter
			logic [3:0] warn_reg, warn_next;        // clock-run warning count
			logic       card_bus_clock_reg, card_bus_clock_next;
			logic       run_oe_reg, run_oe_next;
			logic       rst_n_reg, rst_n_next;
			logic       run_out_reg, run_out_next;      // level shown on clock-run
			logic       float_reg, float_next;          // card lines released
			logic       we_n_reg, we_n_next;
			logic       oe_n_reg, oe_n_next;
			logic       attr_n_reg, attr_n_next;
			logic       done_reg, done_next;
			logic [1:0] volt_reg, volt_next;
			logic       wp_reg, wp_next, io16_reg, io16_next, dreq_reg, dreq_next;
			logic       wait_s, prot_s, run_s, rise;

			// two-flop synchroniser for all card inputs
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					sync1_reg <= 5'h1F;
					sync2_reg <= 5'h1F;
				end else begin
					sync1_reg <= {card_clock_run_in[s], write_protect[s], wait_n[s],
					              voltage_sense_two[s], voltage_sense_one[s]};
					sync2_reg <= sync1_reg;
				end
			end
			assign wait_s = sync2_reg[2];
			assign prot_s = sync2_reg[3];
			assign run_s  = sync2_reg[4];

			// ----------------------------------------------------
			// next-state logic
			// ----------------------------------------------------
			always_comb begin
				wr_next      = wr_reg;
				str_cnt_next = str_cnt_reg;
				div_next     = div_reg;
				tick_next    = tick_reg;
				warn_next    = warn_reg;
				card_bus_clock_next    = card_bus_clock_reg;
				run_oe_next  = 1'b0;
				rst_n_next   = rst_n_reg;
				we_n_next    = 1'b1;
				oe_n_next    = 1'b1;
				done_next    = 1'b0;
				rise         = 1'b0;
				// supply class follows the sense pins continuously
				volt_next    = 2'(volt_decode(sync2_reg[0], sync2_reg[1]));  // [R1]
				// attribute select low only for attribute or io space
				attr_n_next  = ~(attr_space[s] | io_mode[s]);                 // [R14]

				// card clock: divider, stop holds the clock low
				if (stop_clock_req[s] && !card_bus_clock_reg) begin
					tick_next = CNT_RST;                                      // [R9]
				end else if (tick_reg >= div_reg) begin
					tick_next = CNT_RST;
					card_bus_clock_next = ~card_bus_clock_reg;                                    // [R9]
					rise      = ~card_bus_clock_reg;
				end else begin
					tick_next = 4'(tick_reg + 4'h1);
				end

				// card pulling clock-run low asks for full speed
				if (!run_s) begin
					div_next  = DIV_FULL;                                     // [R10]
					warn_next = CNT_RST;
				end else if (slow_clock_req[s] && div_reg != DIV_SLOW) begin
					// drive clock-run high as advance notice, then slow
					run_oe_next = 1'b1;                                       // [R11]
					if (warn_reg == CLKRUN_WARN) begin
						div_next  = DIV_SLOW;
						warn_next = CNT_RST;
					end else begin
						warn_next = 4'(warn_reg + 4'h1);
					end
				end else if (!slow_clock_req[s]) begin
					div_next  = DIV_FULL;
					warn_next = CNT_RST;
				end

				// reset: assert at once, release only on a card clock rise
				if (card_reset_req[s]) begin
					rst_n_next = 1'b0;                                        // [R13]
				end else if (rise) begin
					rst_n_next = 1'b1;                                        // [R13]
				end

				// write strobe sequencer
				case (wr_reg)
					st_idle: begin
						if (mem_write_req[s] && !io_mode[s]) begin
							wr_next      = st_strobe;
							str_cnt_next = STROBE_CYC;
							we_n_next    = 1'b0;                              // [R3]
						end
					end
					st_strobe: begin
						we_n_next = 1'b0;                                     // [R3]
						if (str_cnt_reg != STROBE_RST) begin
							str_cnt_next = 6'(str_cnt_reg - 6'h01);
						end else begin
							wr_next = st_wait;
						end
					end
					st_wait: begin
						// card stretches the cycle while wait is low
						we_n_next = 1'b0;                                     // [R2]
						if (wait_s) begin
							we_n_next = 1'b1;
							wr_next   = st_done;
						end
					end
					st_done: begin
						done_next = 1'b1;
						wr_next   = st_idle;
					end
					default: wr_next = st_idle;
				endcase

				// dma terminal count overlays on the strobes
				if (dma_read_tc_req[s]) begin
					we_n_next = 1'b0;                                         // [R4]
				end
				if (dma_write_tc_req[s]) begin
					oe_n_next = 1'b0;                                         // [R15]
				end

				// while in reset the card lines are released
				if (!rst_n_next) begin
					we_n_next = 1'b1;                                         // [R12]
					oe_n_next = 1'b1;                                         // [R12]
					wr_next   = st_idle;
				end

				// the level on clock-run follows its enable: high while warning,
				// low once released, so the pin never carries a stale high
				run_out_next = run_oe_next;                                   // [R11]
				// lines float for exactly as long as card reset is held
				float_next   = ~rst_n_next;                                   // [R12]
			end

			// protect line meaning depends on mode; taken on card clock rise
			always_comb begin
				wp_next   = wp_reg;
				io16_next = io16_reg;
				dreq_next = dreq_reg;
				if (rise) begin                                               // [R8]
					wp_next   = !io_mode[s] && prot_s;                        // [R5]
					io16_next = io_mode[s] && !prot_s;                        // [R6]
					dreq_next = prot_s;                                       // [R7]
				end
			end

			// ----------------------------------------------------
			// state registers
			// ----------------------------------------------------
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					wr_reg      <= st_idle;
					str_cnt_reg <= STROBE_RST;
					div_reg     <= DIV_RST;
					tick_reg    <= CNT_RST;
					warn_reg    <= CNT_RST;
					card_bus_clock_reg    <= 1'b0;
					run_oe_reg  <= 1'b0;
					rst_n_reg   <= 1'b0;
					run_out_reg <= 1'b0;
					float_reg   <= 1'b1;
					we_n_reg    <= 1'b1;
					oe_n_reg    <= 1'b1;
					attr_n_reg  <= 1'b1;
					done_reg    <= 1'b0;
					volt_reg    <= 2'h0;
					wp_reg      <= 1'b0;
					io16_reg    <= 1'b0;
					dreq_reg    <= 1'b0;
				end else begin
					wr_reg      <= wr_next;
					str_cnt_reg <= str_cnt_next;
					div_reg     <= div_next;
					tick_reg    <= tick_next;
					warn_reg    <= warn_next;
					card_bus_clock_reg    <= card_bus_clock_next;
					run_oe_reg  <= run_oe_next;
					rst_n_reg   <= rst_n_next;
					run_out_reg <= run_out_next;
					float_reg   <= float_next;
					we_n_reg    <= we_n_next;
					oe_n_reg    <= oe_n_next;
					attr_n_reg  <= attr_n_next;
					done_reg    <= done_next;
					volt_reg    <= volt_next;
					wp_reg      <= wp_next;
					io16_reg    <= io16_next;
					dreq_reg    <= dreq_next;
				end
			end

			// outputs straight from flops
			assign write_en_n[s]           = we_n_reg;
			assign output_en_n[s]          = oe_n_reg;
			assign attr_sel_n[s]           = attr_n_reg;
			assign card_bus_clock[s]       = card_bus_clock_reg;
			// clock-run level has its own flop; high only while the warning runs
			assign card_clock_run_out[s]   = run_out_reg;
			assign card_clock_run_oe[s]    = run_oe_reg;
			assign card_bus_reset_n[s]     = rst_n_reg;
			// float flag has a flop of its own, so the pin leaves a register
			// directly and changes on the same edge as the reset pin
			assign card_lines_float[s]     = float_reg;   // [R12]
			assign card_volt[2*s +: 2]     = volt_reg;
			assign write_done[s]           = done_reg;
			assign write_protected[s]      = wp_reg;
			assign port_sixteen_bit_ind[s] = io16_reg;
			assign dma_request[s]          = dreq_reg;
		end
	endgenerate

endmodule : card_socket_ctrl

// ==== rtl/card_socket_pkg.sv ====
package card_socket_pkg;

	// ------------------------------------------------------------
	// supply decode
	// ------------------------------------------------------------
	// decoded supply class from the two sense lines
	typedef enum logic [1:0] {
		volt_5v,     // both sense lines open (high)
		volt_3v,     // sense one grounded
		volt_xv,     // sense two grounded
		volt_lv      // both grounded
	} card_volt_e;

	// ------------------------------------------------------------
	// socket count and clock control
	// ------------------------------------------------------------
	localparam int        SOCKET_COUNT   = 2;
	// card clock divider values: full rate toggles every host clock
	localparam logic [3:0] DIV_FULL      = 4'h0;
	localparam logic [3:0] DIV_SLOW      = 4'h7;
	// last warning count: the clock-run warning is held this many cycles plus one before the clock slows
	localparam logic [3:0] CLKRUN_WARN   = 4'h4;
	// reset values
	localparam logic [3:0] DIV_RST       = 4'h0;
	localparam logic [3:0] CNT_RST       = 4'h0;

	// ------------------------------------------------------------
	// 16-bit access strobe timing
	// ------------------------------------------------------------
	// least width of a write strobe, in ns, and cycles at 4 ns
	localparam int         STROBE_NS     = 60;
	localparam int         CLK_NS        = 4;
	localparam logic [5:0] STROBE_CYC    = 6'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [5:0] STROBE_RST    = 6'h00;

endpackage : card_socket_pkg

// ==== testbench/card_model.sv ====
// stand-in for one inserted card on one socket
module card_model (
	input  wire logic       clock,
	input  wire logic       write_en_n,
	input  wire logic       card_bus_clock,
	input  wire logic       run_drive,
	input  wire logic       run_level,
	input  wire logic [1:0] vcode,
	input  wire logic [7:0] wait_len,
	input  wire logic       wp_sw,
	input  wire logic       fast_req,
	output logic            vs_one,
	output logic            vs_two,
	output logic            wait_n,
	output logic            write_protect,
	output logic            run_in
);
	timeunit 1ns;
	timeprecision 1ps;
	int   wcnt = 0;     // host cycles of wait still to hold
	logic we_q = 1'b1;  // last strobe level, finds its fall
	initial write_protect = 1'b0;
	// a set code bit grounds that sense line
	assign vs_one = ~vcode[0];
	assign vs_two = ~vcode[1];
	// controller drive wins; else card pulls low to ask for speed, else pull-up
	assign run_in = run_drive ? run_level : ~fast_req;
	// stretch each strobe by wait_len cycles from its fall
	always @(posedge clock) begin
		we_q <= write_en_n;
		if (we_q && !write_en_n)
			wcnt <= int'(wait_len);
		else if (wcnt > 0)
			wcnt <= wcnt - 1;
	end
	assign wait_n = (wcnt == 0);
	// switch, port hit and request change only on a card clock rise
	always @(posedge card_bus_clock) begin
		write_protect <= wp_sw;
	end
endmodule : card_model

// ==== testbench/card_socket_ctrl_assertions.sv ====
module card_socket_checks
	import card_socket_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    rstn,
	input wire logic [SOCKET_COUNT-1:0] wait_n,
	input wire logic [SOCKET_COUNT-1:0] dma_read_tc_req,
	input wire logic [SOCKET_COUNT-1:0] dma_write_tc_req,
	input wire logic [SOCKET_COUNT-1:0] attr_space,
	input wire logic [SOCKET_COUNT-1:0] io_mode,
	input wire logic [SOCKET_COUNT-1:0] stop_clock_req,
	input wire logic [SOCKET_COUNT-1:0] write_en_n,
	input wire logic [SOCKET_COUNT-1:0] output_en_n,
	input wire logic [SOCKET_COUNT-1:0] attr_sel_n,
	input wire logic [SOCKET_COUNT-1:0] card_bus_clock,
	input wire logic [SOCKET_COUNT-1:0] card_clock_run_out,
	input wire logic [SOCKET_COUNT-1:0] card_clock_run_oe,
	input wire logic [SOCKET_COUNT-1:0] card_bus_reset_n,
	input wire logic [SOCKET_COUNT-1:0] card_lines_float
);
	timeunit 1ns;
	timeprecision 1ps;
	// all checks watch socket zero in the host clock domain
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	AST_WAIT_HOLDS: assert property ((!write_en_n[0] && !wait_n[0]) [*5] |=> !write_en_n[0])
		else $error("strobe ended during wait");
	AST_STROBE_WIDTH: assert property ($fell(write_en_n[0]) && !$past(dma_read_tc_req[0])
		|-> !write_en_n[0] [*8]) else $error("write strobe too short");
	AST_TC_READ: assert property (dma_read_tc_req[0] && card_bus_reset_n[0]
		|-> ##[1:2] !write_en_n[0]) else $error("no read terminal count");
	AST_TC_WRITE: assert property (dma_write_tc_req[0] && card_bus_reset_n[0]
		|-> ##[1:2] !output_en_n[0]) else $error("no write terminal count");
	AST_ATTR_LOW: assert property ((attr_space[0] || io_mode[0]) [*2] |-> !attr_sel_n[0])
		else $error("attribute select not low");
	AST_RESET_SYNC: assert property ($rose(card_bus_reset_n[0]) |-> $rose(card_bus_clock[0]))
		else $error("card reset released off clock rise");
	AST_FLOAT: assert property (!card_bus_reset_n[0] [*2] |-> card_lines_float[0])
		else $error("lines not floated in reset");
	AST_STOP_LOW: assert property (stop_clock_req[0] [*2] ##0 !card_bus_clock[0]
		|=> !card_bus_clock[0]) else $error("stopped clock left low");
	AST_WARN: assert property ($rose(card_clock_run_oe[0])
		|-> (card_clock_run_oe[0] && card_clock_run_out[0]) [*5]) else $error("warning too short");
	COV_WRITE: cover property ($fell(write_en_n[0]));
	COV_WARN: cover property ($rose(card_clock_run_oe[0]));
	COV_RESET: cover property ($rose(card_bus_reset_n[0]));
endmodule : card_socket_checks

bind card_socket_ctrl card_socket_checks u_checks (.*);

// ==== testbench/card_socket_ctrl_bench.sv ====
module card_socket_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import card_socket_pkg::*;
	logic       clock = 1'b0, rstn = 1'b0;
	logic [1:0] mem_write_req = '0, attr_space = '0, io_mode = '0, card_reset_req = '0;
	logic [1:0] dma_read_tc_req = '0, dma_write_tc_req = '0, slow_clock_req = '0;
	logic [1:0] stop_clock_req = '0, wp_sw = '0, fast_req = '0;
	logic [1:0] vcode [2] = '{2'h0, 2'h0};
	logic [7:0] wait_len [2] = '{8'h00, 8'h00};
	wire  [1:0] voltage_sense_one, voltage_sense_two, wait_n, write_protect, card_clock_run_in;
	logic [1:0] write_en_n, output_en_n, attr_sel_n, card_bus_clock, card_clock_run_out;
	logic [1:0] card_clock_run_oe, card_bus_reset_n, card_lines_float, write_done;
	logic [1:0] write_protected, port_sixteen_bit_ind, dma_request;
	logic [3:0] card_volt;
	int         err_total = 0, compares = 0, cyc = 0, h;
	card_socket_ctrl dut (.*);
	for (genvar s = 0; s < 2; s++) begin : g_card
		card_model m (.clock(clock), .write_en_n(write_en_n[s]), .card_bus_clock(card_bus_clock[s]),
			.run_drive(card_clock_run_oe[s]), .run_level(card_clock_run_out[s]), .vcode(vcode[s]),
			.wait_len(wait_len[s]), .wp_sw(wp_sw[s]), .fast_req(fast_req[s]), .run_in(card_clock_run_in[s]),
			.vs_one(voltage_sense_one[s]), .vs_two(voltage_sense_two[s]), .wait_n(wait_n[s]),
			.write_protect(write_protect[s]));
	end
	always #2 clock = ~clock;
	// a hang is cut short well past the expected run length
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task automatic t_volt;
		for (int v = 0; v < 4; v++) begin
			vcode[0] = v[1:0];
			vcode[1] = ~v[1:0];
			tick(8);
			check(card_volt[1:0], v[1:0], "supply decode");
			check(card_volt[3:2], vcode[1], "other socket decode");
		end
		$display("volt test done");
	endtask : t_volt
	task automatic t_write(input logic [7:0] wl, input logic io);
		int   n = 0;
		logic d = 1'b0;
		wait_len[0] = wl;
		io_mode[0] = io;
		mem_write_req[0] = 1'b1;
		tick(2);
		mem_write_req[0] = 1'b0;
		while (write_en_n[0] === 1'b0 && n < 300) begin
			tick(1);
			n++;
		end
		check(io ? n == 0 : n + 2 > STROBE_CYC && n + 2 >= wl && n < 300, 1'b1, "strobe");
		repeat (3) begin
			d |= write_done[0];
			tick(1);
		end
		check(d, !io, "write done");
		io_mode[0] = 1'b0;
		$display("write test done");
	endtask : t_write
	task automatic t_tc;
		dma_read_tc_req[0] = 1'b1;
		tick(3);
		check({write_en_n[0], output_en_n[0]}, 2'h1, "read count");
		dma_read_tc_req[0] = 1'b0;
		dma_write_tc_req[0] = 1'b1;
		tick(3);
		check({write_en_n[0], output_en_n[0]}, 2'h2, "write count");
		dma_write_tc_req[0] = 1'b0;
		tick(3);
		for (int k = 0; k < 4; k++) begin
			{attr_space[0], io_mode[0]} = k[1:0];
			tick(3);
			check(attr_sel_n[0], k == 0, "attribute select");
		end
		{attr_space[0], io_mode[0]} = 2'h0;
		$display("strobe test done");
	endtask : t_tc
	task automatic t_prot;
		wp_sw[0] = 1'b1;
		tick(20);
		check(write_protected[0], 1'b1, "protect");
		check(dma_request[0], 1'b1, "dma request");
		// a port hit is the card pulling the shared line low in io mode
		io_mode[0] = 1'b1;
		wp_sw[0] = 1'b0;
		tick(20);
		check(port_sixteen_bit_ind[0], 1'b1, "port hit");
		check({write_protected[0], dma_request[0]}, 2'h0, "protect in io mode");
		io_mode[0] = 1'b0;
		tick(20);
		check({write_protected[0], port_sixteen_bit_ind[0]}, 2'h0, "protect off");
		$display("protect test done");
	endtask : t_prot
	task automatic half(output int hc);
		logic c = card_bus_clock[0];
		hc = 0;
		while (card_bus_clock[0] === c && hc < 40) begin
			tick(1);
			hc++;
		end
		c = card_bus_clock[0];
		hc = 0;
		while (card_bus_clock[0] === c && hc < 40) begin
			tick(1);
			hc++;
		end
	endtask : half
	task automatic t_clock;
		half(h);
		check(h == 1, 1'b1, "full rate");
		slow_clock_req[0] = 1'b1;
		tick(2);
		check({card_clock_run_oe[0], card_clock_run_out[0]}, 2'h3, "slow warning");
		tick(20);
		check({card_clock_run_oe[0], card_clock_run_out[0]}, 2'h0, "warning over");
		half(h);
		check(h == DIV_SLOW + 1, 1'b1, "slow rate");
		fast_req[0] = 1'b1;
		tick(40);
		half(h);
		check(h == 1, 1'b1, "card asks speed");
		{fast_req[0], slow_clock_req[0], stop_clock_req[0]} = 3'h1;
		tick(40);
		check(card_bus_clock[0], 1'b0, "stopped low");
		stop_clock_req[0] = 1'b0;
		$display("clock test done");
	endtask : t_clock
	task automatic t_reset;
		card_reset_req[0] = 1'b1;
		tick(4);
		check({card_bus_reset_n[0], card_lines_float[0]}, 2'h1, "card reset");
		check(card_bus_reset_n[1], 1'b1, "other socket reset");
		card_reset_req[0] = 1'b0;
		tick(10);
		check(card_bus_reset_n[0], 1'b1, "card reset off");
		$display("reset test done");
	endtask : t_reset
	initial begin
		tick(4);
		rstn = 1'b1;
		tick(20);
		t_volt();
		t_write(8'h00, 1'b0);
		t_write(8'h30, 1'b0);
		t_write(8'h00, 1'b1);
		t_tc();
		t_prot();
		t_clock();
		t_reset();
		tally_and_finish();
	end
endmodule : card_socket_ctrl_bench
